/* File: rtl/vdec_ctrl_pkg.sv */
package vdec_ctrl_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_INPUT_SOURCE_SELECT  = 8'h00;
    localparam logic [7:0] ADDR_ANALOG_FRONT_END     = 8'h01;
    localparam logic [7:0] ADDR_OPERATION_MODE       = 8'h02;
    localparam logic [7:0] ADDR_MISCELLANEOUS        = 8'h03;
    localparam logic [7:0] ADDR_STANDARD_AUTOSWITCH  = 8'h04;
    localparam logic [7:0] ADDR_SOFT_RESET           = 8'h05;
    localparam logic [7:0] ADDR_CHROMA_KILL          = 8'h06;
    localparam logic [7:0] ADDR_LUMA_PROCESSING      = 8'h07;
    localparam int         REG_COUNT                 = 8;
    localparam int         REG_AW                    = 3;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_INPUT_SOURCE_SELECT   = 8'h00;
    localparam logic [7:0] RST_ANALOG_FRONT_END      = 8'h15;
    localparam logic [7:0] RST_OPERATION_MODE        = 8'h00;
    localparam logic [7:0] RST_MISCELLANEOUS         = 8'h01;
    localparam logic [7:0] RST_STANDARD_AUTOSWITCH   = 8'h1c;
    localparam logic [7:0] RST_SOFT_RESET            = 8'h00;
    localparam logic [7:0] RST_CHROMA_KILL           = 8'h10;
    localparam logic [7:0] RST_LUMA_PROCESSING       = 8'h20;

    // ------------------------------------------------------------
    // writable bit masks (reserved bits read zero)
    // ------------------------------------------------------------
    localparam logic [7:0] MASK_INPUT_SOURCE_SELECT  = 8'h03;
    localparam logic [7:0] MASK_ANALOG_FRONT_END     = 8'h1f;
    localparam logic [7:0] MASK_OPERATION_MODE       = 8'h05;
    localparam logic [7:0] MASK_MISCELLANEOUS        = 8'hff;
    localparam logic [7:0] MASK_STANDARD_AUTOSWITCH  = 8'h1c;
    localparam logic [7:0] MASK_SOFT_RESET           = 8'h00;
    localparam logic [7:0] MASK_CHROMA_KILL          = 8'h7f;
    localparam logic [7:0] MASK_LUMA_PROCESSING      = 8'hff;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BIT_SVIDEO_SELECT     = 0;
    localparam int BIT_CHANNEL1_SOURCE   = 1;
    localparam int POS_GAIN_CONTROL      = 0;
    localparam int POS_OFFSET_CONTROL    = 2;
    localparam int BIT_POWER_DOWN        = 0;
    localparam int BIT_SUBCARRIER_FREEZE = 2;
    localparam int BIT_CLOCK_OUT_EN      = 0;
    localparam int BIT_VBLANK_ON         = 1;
    localparam int BIT_SYNC_OUT_EN       = 2;
    localparam int BIT_PIXEL_OUT_EN      = 3;
    localparam int BIT_LOCK_STATUS_SEL   = 4;
    localparam int BIT_GP_PIN_DIR        = 5;
    localparam int BIT_GP_PIN_VALUE      = 6;
    localparam int BIT_PIN27_FUNCTION    = 7;
    localparam int BIT_PALM_ALLOW        = 2;
    localparam int BIT_PALN_ALLOW        = 3;
    localparam int BIT_NTSC443_ALLOW     = 4;
    localparam int BIT_SOFT_RESET        = 0;
    localparam int POS_KILL_THRESHOLD    = 0;
    localparam int POS_KILL_MODE         = 5;
    localparam int POS_LUMA_DELAY        = 0;
    localparam int BIT_VBLANK_BYPASS     = 4;
    localparam int BIT_RAW_HEADER_DIS    = 5;
    localparam int BIT_NO_PEDESTAL       = 6;
    localparam int BIT_LUMA_BYPASS       = 7;

    // ------------------------------------------------------------
    // field encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        LOOP_OFF    = 2'b00,
        LOOP_AUTO   = 2'b01,
        LOOP_RSVD   = 2'b10,
        LOOP_FROZEN = 2'b11
    } loop_mode_t;

    typedef enum logic [1:0]
    {
        KILL_AUTO     = 2'b00,
        KILL_RSVD     = 2'b01,
        KILL_FORCED   = 2'b10,
        KILL_DISABLED = 2'b11
    } kill_mode_t;

    localparam logic [7:0] RAW_DUMMY_HEADER = 8'h40;

endpackage

/* File: rtl/ctrl_reg_array.sv */
`timescale 1ns/1ns
`default_nettype none

// eight byte registers with per-register reset value and write mask
module ctrl_reg_array
    import vdec_ctrl_pkg::*;
(
    input  wire logic                         clock,
    input  wire logic                         sys_rst,
    input  wire logic                         soft_clear,
    input  wire logic                         wr_en,
    input  wire logic [vdec_ctrl_pkg::REG_AW-1:0] wr_idx,
    input  wire logic [7:0]                   wr_data,
    input  wire logic [vdec_ctrl_pkg::REG_AW-1:0] rd_idx,
    output logic      [7:0]                   rd_data,
    output logic      [8*vdec_ctrl_pkg::REG_COUNT-1:0] regs_flat
);

    function automatic logic [7:0] reset_of(input int i);
        case (i)
            0:       reset_of = RST_INPUT_SOURCE_SELECT;
            1:       reset_of = RST_ANALOG_FRONT_END;
            2:       reset_of = RST_OPERATION_MODE;
            3:       reset_of = RST_MISCELLANEOUS;
            4:       reset_of = RST_STANDARD_AUTOSWITCH;
            5:       reset_of = RST_SOFT_RESET;
            6:       reset_of = RST_CHROMA_KILL;
            default: reset_of = RST_LUMA_PROCESSING;
        endcase
    endfunction

    function automatic logic [7:0] mask_of(input int i);
        case (i)
            0:       mask_of = MASK_INPUT_SOURCE_SELECT;
            1:       mask_of = MASK_ANALOG_FRONT_END;
            2:       mask_of = MASK_OPERATION_MODE;
            3:       mask_of = MASK_MISCELLANEOUS;
            4:       mask_of = MASK_STANDARD_AUTOSWITCH;
            5:       mask_of = MASK_SOFT_RESET;
            6:       mask_of = MASK_CHROMA_KILL;
            default: mask_of = MASK_LUMA_PROCESSING;
        endcase
    endfunction

    logic [7:0] regs_q [REG_COUNT];
    logic [7:0] regs_d [REG_COUNT];
    logic [7:0] rd_data_d;

    always_comb
    begin
        for (int i = 0; i < REG_COUNT; i++)
        begin
            regs_d[i] = regs_q[i];
            if (soft_clear)
            begin
                regs_d[i] = reset_of(i);
            end
            else if (wr_en && (int'(wr_idx) == i))
            begin
                regs_d[i] = wr_data & mask_of(i);
            end
        end
        rd_data_d = regs_q[rd_idx];
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < REG_COUNT; i++)
            begin
                regs_q[i] <= reset_of(i);
            end
            rd_data <= 8'h00;
        end
        else
        begin
            for (int i = 0; i < REG_COUNT; i++)
            begin
                regs_q[i] <= regs_d[i];
            end
            rd_data <= rd_data_d;
        end
    end

    always_comb
    begin
        for (int i = 0; i < REG_COUNT; i++)
        begin
            regs_flat[8*i +: 8] = regs_q[i];
        end
    end

endmodule // ctrl_reg_array

`default_nettype wire

/* File: rtl/video_decoder_control_regs.sv */
`timescale 1ns/1ns
`default_nettype none

module video_decoder_control_regs
    import vdec_ctrl_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        sys_rst,
    // byte-level side of the serial control engine
    input  wire logic        reg_wr_strobe,
    input  wire logic        reg_rd_strobe,
    input  wire logic [7:0]  reg_subaddr,
    input  wire logic [7:0]  reg_wr_data,
    output logic      [7:0]  reg_rd_data,
    output logic             reg_rd_valid,
    // strap and vbi-side enable
    input  wire logic        active_video_indicator_strap,
    input  wire logic        vbi_output_enable,
    input  wire logic        vbi_enable_programmed,
    // status from the datapath
    input  wire logic        horizontal_lock_flag,
    input  wire logic        vertical_lock_flag,
    input  wire logic        pal_standard_indicator,
    input  wire logic        field_identifier,
    input  wire logic        vertical_blank_output,
    input  wire logic        pal_pins_configured,
    input  wire logic        pin27_shared_enabled,
    // analog front end
    output logic             analog_input_one_b_sel,
    output logic             svideo_mode,
    output logic [1:0]       offset_loop_mode,
    output logic [1:0]       gain_loop_mode,
    output logic             subcarrier_loop_freeze,
    output logic             power_down,
    // pins
    output logic             pin27_function_select,
    input  wire logic        general_purpose_pin_in,
    output logic             general_purpose_pin_out,
    output logic             general_purpose_pin_oe,
    output logic             general_purpose_pin_value,
    output logic             lock_status_select,
    output logic             pin24_status_out,
    output logic             pin23_status_out,
    output logic             pixel_output_enable,
    output logic             sync_output_enable,
    output logic             vertical_blank_enable,
    output logic             sample_clock_enable,
    // standard detection
    output logic             ntsc443_autoswitch_allow,
    output logic             paln_autoswitch_allow,
    output logic             palm_autoswitch_allow,
    output logic             soft_reset_pulse,
    // chroma and luma processing
    output logic [1:0]       chroma_kill_mode,
    output logic [4:0]       chroma_kill_threshold,
    output logic             luma_raw_bypass,
    output logic             pedestal_absent,
    output logic             raw_header_disable,
    output logic [7:0]       raw_header_byte,
    output logic             vblank_luma_bypass,
    output logic [3:0]       luma_delay
);

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function automatic logic addr_mapped(input logic [7:0] a);
        addr_mapped = (a < 8'(REG_COUNT));
    endfunction

    logic                      wr_hit;
    logic [REG_AW-1:0]         idx;
    logic [7:0]                arr_rd;
    logic [8*REG_COUNT-1:0]    regs_flat;
    logic                      soft_clear_q;
    logic                      soft_clear_d;

    assign idx    = reg_subaddr[REG_AW-1:0];
    // reserved addresses are not written; reserved bits are masked off
    assign wr_hit = reg_wr_strobe && addr_mapped(reg_subaddr);

    ctrl_reg_array u_regs
    (
        .clock      (clock),
        .sys_rst    (sys_rst),
        .soft_clear (soft_clear_q),
        .wr_en      (wr_hit),
        .wr_idx     (idx),
        .wr_data    (reg_wr_data),
        .rd_idx     (idx),
        .rd_data    (arr_rd),
        .regs_flat  (regs_flat)
    );

    logic [7:0] r_in;
    logic [7:0] r_afe;
    logic [7:0] r_op;
    logic [7:0] r_misc;
    logic [7:0] r_mask;
    logic [7:0] r_kill;
    logic [7:0] r_luma;

    assign r_in   = regs_flat[8*0 +: 8];
    assign r_afe  = regs_flat[8*1 +: 8];
    assign r_op   = regs_flat[8*2 +: 8];
    assign r_misc = regs_flat[8*3 +: 8];
    assign r_mask = regs_flat[8*4 +: 8];
    assign r_kill = regs_flat[8*6 +: 8];
    assign r_luma = regs_flat[8*7 +: 8];

    // ------------------------------------------------------------
    // strap synchroniser and soft reset
    // ------------------------------------------------------------
    logic [2:0] strap_sync_q;
    logic [2:0] strap_sync_d;
    logic       strap_level_q;
    logic       strap_level_d;
    logic       strap_taken_q;
    logic       strap_taken_d;
    logic [2:0] strap_fill_q;
    logic [2:0] strap_fill_d;
    logic [2:0] gp_sync_q;
    logic [2:0] gp_sync_d;
    logic       gp_level_q;
    logic       gp_level_d;
    logic       misc_programmed_q;
    logic       misc_programmed_d;
    logic       rd_pending_q;
    logic       rd_pending_d;
    logic       rd_ok_q;
    logic       rd_ok_d;

    always_comb
    begin
        strap_sync_d  = {strap_sync_q[1:0], active_video_indicator_strap};
        strap_fill_d  = {strap_fill_q[1:0], 1'b1};
        gp_sync_d     = {gp_sync_q[1:0], general_purpose_pin_in};
        gp_level_d    = (gp_sync_q[1] == gp_sync_q[2]) ? gp_sync_q[2] : gp_level_q;
        strap_level_d = strap_level_q;
        strap_taken_d = strap_taken_q;
        // strap caught once the chain holds real samples and they agree
        if (!strap_taken_q && strap_fill_q[2] && (strap_sync_q[1] == strap_sync_q[2]))
        begin
            strap_level_d = strap_sync_q[2];
            strap_taken_d = 1'b1;
        end
        misc_programmed_d = misc_programmed_q;
        if (soft_clear_q)
        begin
            misc_programmed_d = 1'b0;
        end
        if (wr_hit && (reg_subaddr == ADDR_MISCELLANEOUS))
        begin
            misc_programmed_d = 1'b1;
        end
        // writing 1 to the reset bit clears the bank next cycle
        soft_clear_d = wr_hit && (reg_subaddr == ADDR_SOFT_RESET)
                       && reg_wr_data[BIT_SOFT_RESET];
        rd_pending_d = reg_rd_strobe;
        rd_ok_d      = addr_mapped(reg_subaddr);
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            strap_sync_q      <= 3'b000;
            strap_fill_q      <= 3'b000;
            gp_sync_q         <= 3'b000;
            gp_level_q        <= 1'b0;
            strap_level_q     <= 1'b0;
            strap_taken_q     <= 1'b0;
            misc_programmed_q <= 1'b0;
            soft_clear_q      <= 1'b0;
            rd_pending_q      <= 1'b0;
            rd_ok_q           <= 1'b0;
        end
        else
        begin
            strap_sync_q      <= strap_sync_d;
            strap_fill_q      <= strap_fill_d;
            gp_sync_q         <= gp_sync_d;
            gp_level_q        <= gp_level_d;
            strap_level_q     <= strap_level_d;
            strap_taken_q     <= strap_taken_d;
            misc_programmed_q <= misc_programmed_d;
            soft_clear_q      <= soft_clear_d;
            rd_pending_q      <= rd_pending_d;
            rd_ok_q           <= rd_ok_d;
        end
    end

    // ------------------------------------------------------------
    // decoded controls
    // ------------------------------------------------------------
    typedef struct packed
    {
        logic       in_b;
        logic       svid;
        logic [1:0] offs;
        logic [1:0] gain;
        logic       freeze;
        logic       pdown;
        logic       p27;
        logic       gp_out;
        logic       gp_oe;
        logic       gp_val;
        logic       lock_sel;
        logic       p24;
        logic       p23;
        logic       pix_oe;
        logic       sync_oe;
        logic       vblank_en;
        logic       sclk_en;
        logic       n443;
        logic       paln;
        logic       palm;
        logic [1:0] kmode;
        logic [4:0] kthr;
        logic       lbyp;
        logic       noped;
        logic       hdr_dis;
        logic [7:0] hdr;
        logic       vbyp;
        logic [3:0] ldly;
        logic [7:0] rdata;
        logic       rvalid;
    } outs_t;

    outs_t o_q;
    outs_t o_d;

    always_comb
    begin
        o_d = o_q;
        // s-video takes luma on 1A, so the 1B select is forced off
        o_d.svid   = r_in[BIT_SVIDEO_SELECT];
        o_d.in_b   = r_in[BIT_CHANNEL1_SOURCE]
                     && !r_in[BIT_SVIDEO_SELECT];
        o_d.offs   = r_afe[POS_OFFSET_CONTROL +: 2];
        o_d.gain   = r_afe[POS_GAIN_CONTROL +: 2];
        o_d.freeze = r_op[BIT_SUBCARRIER_FREEZE];
        o_d.pdown  = r_op[BIT_POWER_DOWN];
        o_d.p27    = r_misc[BIT_PIN27_FUNCTION];
        o_d.gp_oe  = r_misc[BIT_GP_PIN_DIR]
                     && pin27_shared_enabled
                     && !r_misc[BIT_PIN27_FUNCTION];
        o_d.gp_out = r_misc[BIT_GP_PIN_VALUE];
        o_d.gp_val = r_misc[BIT_GP_PIN_DIR] ? r_misc[BIT_GP_PIN_VALUE]
                                            : gp_level_q;
        o_d.lock_sel = r_misc[BIT_LOCK_STATUS_SEL];
        if (r_misc[BIT_LOCK_STATUS_SEL] && pal_pins_configured)
        begin
            o_d.p24 = horizontal_lock_flag;
            o_d.p23 = vertical_lock_flag;
        end
        else
        begin
            o_d.p24 = pal_standard_indicator;
            o_d.p23 = field_identifier;
        end
        if (misc_programmed_q && vbi_enable_programmed)
        begin
            o_d.pix_oe = r_misc[BIT_PIXEL_OUT_EN]
                         && vbi_output_enable;
        end
        else
        begin
            o_d.pix_oe = strap_level_q;
        end
        o_d.sync_oe = r_misc[BIT_SYNC_OUT_EN];
        o_d.vblank_en = r_misc[BIT_VBLANK_ON] && vertical_blank_output;
        o_d.sclk_en = r_misc[BIT_CLOCK_OUT_EN];
        o_d.n443    = r_mask[BIT_NTSC443_ALLOW];
        o_d.paln    = r_mask[BIT_PALN_ALLOW];
        o_d.palm    = r_mask[BIT_PALM_ALLOW];
        o_d.kmode   = r_kill[POS_KILL_MODE +: 2];
        o_d.kthr    = r_kill[POS_KILL_THRESHOLD +: 5];
        o_d.lbyp    = r_luma[BIT_LUMA_BYPASS];
        o_d.noped   = r_luma[BIT_NO_PEDESTAL];
        o_d.hdr_dis = r_luma[BIT_RAW_HEADER_DIS];
        o_d.hdr     = r_luma[BIT_RAW_HEADER_DIS] ? RAW_DUMMY_HEADER
                                                 : 8'h00;
        o_d.vbyp    = r_luma[BIT_VBLANK_BYPASS];
        o_d.ldly    = r_luma[POS_LUMA_DELAY +: 4];
        o_d.rvalid  = rd_pending_q;
        o_d.rdata   = (rd_pending_q && rd_ok_q) ? arr_rd : 8'h00;
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            o_q         <= '0;
        end
        else
        begin
            o_q <= o_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign analog_input_one_b_sel   = o_q.in_b;
    assign svideo_mode              = o_q.svid;
    assign offset_loop_mode         = o_q.offs;
    assign gain_loop_mode           = o_q.gain;
    assign subcarrier_loop_freeze   = o_q.freeze;
    assign power_down               = o_q.pdown;
    assign pin27_function_select    = o_q.p27;
    assign general_purpose_pin_out  = o_q.gp_out;
    assign general_purpose_pin_oe   = o_q.gp_oe;
    assign general_purpose_pin_value = o_q.gp_val;
    assign lock_status_select       = o_q.lock_sel;
    assign pin24_status_out         = o_q.p24;
    assign pin23_status_out         = o_q.p23;
    assign pixel_output_enable      = o_q.pix_oe;
    assign sync_output_enable       = o_q.sync_oe;
    assign vertical_blank_enable    = o_q.vblank_en;
    assign sample_clock_enable      = o_q.sclk_en;
    assign ntsc443_autoswitch_allow = o_q.n443;
    assign paln_autoswitch_allow    = o_q.paln;
    assign palm_autoswitch_allow    = o_q.palm;
    assign soft_reset_pulse         = soft_clear_q;
    assign chroma_kill_mode         = o_q.kmode;
    assign chroma_kill_threshold    = o_q.kthr;
    assign luma_raw_bypass          = o_q.lbyp;
    assign pedestal_absent          = o_q.noped;
    assign raw_header_disable       = o_q.hdr_dis;
    assign raw_header_byte          = o_q.hdr;
    assign vblank_luma_bypass       = o_q.vbyp;
    assign luma_delay               = o_q.ldly;
    assign reg_rd_data              = o_q.rdata;
    assign reg_rd_valid             = o_q.rvalid;

endmodule // video_decoder_control_regs

`default_nettype wire

/* File: tb/vdec_regs_props.sv */
`timescale 1ns/1ns
`default_nettype none
module vdec_regs_props (
    input wire logic       clock,
    input wire logic       sys_rst,
    input wire logic       reg_wr_strobe,
    input wire logic       reg_rd_strobe,
    input wire logic [7:0] reg_subaddr,
    input wire logic [7:0] reg_wr_data,
    input wire logic [7:0] reg_rd_data,
    input wire logic       reg_rd_valid,
    input wire logic       sample_clock_enable,
    input wire logic       palm_autoswitch_allow,
    input wire logic       soft_reset_pulse
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    sequence s_wr(logic [7:0] a); reg_wr_strobe && reg_subaddr == a; endsequence
    sequence s_rd(logic [7:0] a); reg_rd_strobe && reg_subaddr == a; endsequence
    sequence s_sr; reg_wr_strobe && reg_subaddr == 8'h05 && reg_wr_data[0]; endsequence
    chk_rd_latency: assert property (reg_rd_strobe |-> ##2 reg_rd_valid)
        else $error("read valid late");
    chk_unmapped_zero: assert property (reg_rd_strobe && reg_subaddr > 8'h07 |->
        ##2 reg_rd_data == 8'h00) else $error("unmapped read not zero");
    chk_soft_rd_zero: assert property (s_rd(8'h05) |-> ##2 reg_rd_data == 8'h00)
        else $error("soft reset reads nonzero");
    chk_sclk_write: assert property (s_wr(8'h03) |->
        ##2 sample_clock_enable == $past(reg_wr_data[0], 2)) else $error("sclk enable wrong");
    chk_mask_write: assert property (s_wr(8'h04) |->
        ##2 palm_autoswitch_allow == $past(reg_wr_data[2], 2)) else $error("mask wrong");
    chk_pulse_once: assert property (soft_reset_pulse |=> !soft_reset_pulse)
        else $error("soft pulse too long");
    chk_pulse_cause: assert property (s_sr |-> ##[1:2] soft_reset_pulse)
        else $error("no soft pulse");
    chk_soft_restore: assert property (soft_reset_pulse |->
        ##[0:3] (sample_clock_enable && palm_autoswitch_allow)) else $error("not restored");
endmodule // vdec_regs_props
bind video_decoder_control_regs vdec_regs_props vdec_regs_props_i (.*);
`default_nettype wire

/* File: tb/cpu_host.sv */
`timescale 1ns/1ns
`default_nettype none
module cpu_host (
    input  wire logic       clock,
    input  wire logic       reg_rd_valid,
    input  wire logic [7:0] reg_rd_data,
    output logic            reg_wr_strobe,
    output logic            reg_rd_strobe,
    output logic      [7:0] reg_subaddr,
    output logic      [7:0] reg_wr_data
);
    logic [7:0] rd_byte;
    logic       rd_ok;
    initial {reg_wr_strobe, reg_rd_strobe, reg_subaddr, reg_wr_data} = '0;
    // released address and data show the inverse, never the old value
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock) {reg_wr_strobe, reg_subaddr, reg_wr_data} = {1'b1, a, d};
        @(negedge clock) {reg_wr_strobe, reg_subaddr, reg_wr_data} = {1'b0, ~a, ~d};
        repeat (2) @(negedge clock);
    endtask
    task automatic rd(input logic [7:0] a);
        @(negedge clock) {reg_rd_strobe, reg_subaddr} = {1'b1, a};
        @(negedge clock) {reg_rd_strobe, reg_subaddr} = {1'b0, ~a};
        rd_ok = 1'b0;
        repeat (4)
        begin
            if (reg_rd_valid === 1'b1) {rd_ok, rd_byte} = {1'b1, reg_rd_data};
            @(negedge clock);
        end
    endtask
endmodule // cpu_host
`default_nettype wire

/* File: tb/video_decoder_control_regs_test.sv */
`timescale 1ns/1ns
`default_nettype none
module video_decoder_control_regs_test;
    logic clock, sys_rst, reg_wr_strobe, reg_rd_strobe, reg_rd_valid, svideo_mode, power_down;
    logic [7:0] reg_subaddr, reg_wr_data, reg_rd_data, raw_header_byte;
    logic [1:0] offset_loop_mode, gain_loop_mode, chroma_kill_mode;
    logic [4:0] chroma_kill_threshold;
    logic [3:0] luma_delay;
    logic active_video_indicator_strap, vbi_output_enable, vbi_enable_programmed;
    logic horizontal_lock_flag, vertical_lock_flag, pal_standard_indicator, field_identifier;
    logic vertical_blank_output, pal_pins_configured, pin27_shared_enabled;
    logic general_purpose_pin_in, general_purpose_pin_out, general_purpose_pin_oe;
    logic general_purpose_pin_value, analog_input_one_b_sel, subcarrier_loop_freeze;
    logic pin27_function_select, lock_status_select, pin24_status_out, pin23_status_out;
    logic pixel_output_enable, sync_output_enable, vertical_blank_enable, sample_clock_enable;
    logic ntsc443_autoswitch_allow, paln_autoswitch_allow, palm_autoswitch_allow;
    logic soft_reset_pulse, luma_raw_bypass, pedestal_absent, raw_header_disable;
    logic vblank_luma_bypass;
    int   error_cnt = 0;
    int   cmp_count = 0;
    video_decoder_control_regs video_decoder_control_regs_i (.*);
    cpu_host cpu_host_i (.*);
    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e)
        begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rd_cmp(input logic [7:0] a, input logic [7:0] e);
        cpu_host_i.rd(a);
        cmp("read valid", 8'h01, {7'h0, cpu_host_i.rd_ok});
        cmp("read byte", e, cpu_host_i.rd_byte);
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic t_reset;
        logic [7:0] rv [8] = '{8'h00, 8'h15, 8'h00, 8'h01, 8'h1c, 8'h00, 8'h10, 8'h20};
        for (int i = 0; i < 8; i++) rd_cmp(8'(i), rv[i]);
        cmp("pixel strap", 8'h01, {7'h0, pixel_output_enable});
        cmp("kill threshold", 8'h10, {3'h0, chroma_kill_threshold});
        cmp("raw header", 8'h01, {7'h0, raw_header_disable});
        cmp("raw header byte", 8'h40, raw_header_byte);
    endtask
    task automatic t_fields;
        cpu_host_i.wr(8'h00, 8'h03);
        cmp("s-video", 8'h01, {6'h0, analog_input_one_b_sel, svideo_mode});
        cpu_host_i.wr(8'h00, 8'h02);
        cmp("input 1b", 8'h02, {6'h0, analog_input_one_b_sel, svideo_mode});
        cpu_host_i.wr(8'h01, 8'h0f);
        cmp("loops", 8'h0f, {4'h0, offset_loop_mode, gain_loop_mode});
        cpu_host_i.wr(8'h02, 8'h05);
        cmp("mode", 8'h03, {6'h0, subcarrier_loop_freeze, power_down});
        cpu_host_i.wr(8'h04, 8'h00);
        cmp("autoswitch", 8'h00, {5'h0, ntsc443_autoswitch_allow, paln_autoswitch_allow,
            palm_autoswitch_allow});
        cpu_host_i.wr(8'h06, 8'h5f);
        cmp("killer", 8'h5f, {1'b0, chroma_kill_mode, chroma_kill_threshold});
        cpu_host_i.wr(8'h07, 8'hdf);
        cmp("luma", 8'hdf, {luma_raw_bypass, pedestal_absent, raw_header_disable,
            vblank_luma_bypass, luma_delay});
        cmp("raw header off", 8'h00, raw_header_byte);
    endtask
    task automatic t_pins;
        {vbi_output_enable, vbi_enable_programmed, pin27_shared_enabled} = 3'b111;
        {pal_pins_configured, horizontal_lock_flag, vertical_lock_flag} = 3'b110;
        {general_purpose_pin_in, vertical_blank_output} = 2'b11;
        cpu_host_i.wr(8'h03, 8'h7c);
        cmp("gp pin", 8'h07, {5'h0, general_purpose_pin_oe, general_purpose_pin_out,
            general_purpose_pin_value});
        cmp("lock", 8'h06, {5'h0, lock_status_select, pin24_status_out, pin23_status_out});
        cmp("enables", 8'h0c, {4'h0, pixel_output_enable, sync_output_enable,
            vertical_blank_enable, sample_clock_enable});
        vbi_output_enable = 1'b0;
        repeat (3) @(negedge clock);
        cmp("pixel vbi off", 8'h00, {7'h0, pixel_output_enable});
        cpu_host_i.wr(8'h03, 8'h82);
        cmp("pin27", 8'h0b, {4'h0, pin27_function_select, general_purpose_pin_oe,
            general_purpose_pin_value, vertical_blank_enable});
    endtask
    task automatic t_soft;
        cpu_host_i.wr(8'h05, 8'h01);
        rd_cmp(8'h00, 8'h00);
        rd_cmp(8'h03, 8'h01);
        rd_cmp(8'h05, 8'h00);
        rd_cmp(8'h08, 8'h00);
    endtask
    initial
    begin
        sys_rst = 1'b1;
        {active_video_indicator_strap, vbi_output_enable, vbi_enable_programmed} = 3'b100;
        {horizontal_lock_flag, vertical_lock_flag, pal_standard_indicator} = '0;
        {field_identifier, vertical_blank_output, pal_pins_configured} = '0;
        {pin27_shared_enabled, general_purpose_pin_in} = '0;
        repeat (20) @(negedge clock);
        sys_rst = 1'b0;
        repeat (6) @(negedge clock);
        t_reset;
        t_fields;
        t_pins;
        t_soft;
        end_of_test;
    end
endmodule // video_decoder_control_regs_test
`default_nettype wire
